// ---- hw/lyo_pkg.sv ----
// Constants and types for the layer overlay and character RAM base block.
// Assumes a byte-wide register port decoded by the surrounding controller.
package lyo_pkg;
	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] LYO_OFS_COMPOSE = 8'h18;
	localparam logic [7:0] LYO_OFS_BASE_LO = 8'h19;
	localparam logic [7:0] LYO_OFS_BASE_HI = 8'h1A;
	localparam logic [7:0] LYO_RST_COMPOSE = 8'h00;
	localparam logic [7:0] LYO_RST_BASE = 8'h00;
	// Indirect command codes, equal to the register offsets
	localparam logic [7:0] LYO_CMD_OVERLAY = 8'h18;
	localparam logic [7:0] LYO_CMD_BASE = 8'h19;
	// ****************************************
	// Field positions
	// ****************************************
	localparam int LYO_BIT_THREE = 4;
	localparam int LYO_BIT_BLK3 = 3;
	localparam int LYO_BIT_BLK1 = 2;
	localparam int LYO_BIT_MIX = 0;
	localparam logic [7:0] LYO_COMPOSE_MASK = 8'h1F;
	localparam logic [1:0] LYO_MIX_OR = 2'h0;
	localparam logic [1:0] LYO_MIX_XOR = 2'h1;
	localparam logic [1:0] LYO_MIX_AND = 2'h2;
	// Host-side write request
	typedef struct packed {
		logic wr;
		logic indirect;
		logic [7:0] addr;
		logic [7:0] data;
	} lyo_req_t;
	// Pixel request: three layer bits plus block 3 select
	typedef struct packed {
		logic blk3;
		logic first;
		logic second;
		logic third;
	} lyo_pix_t;
endpackage : lyo_pkg

// ---- hw/lyo_overlay.sv ----
// Layer composition settings, pixel mixing and character pattern address.
// Assumes host requests are synchronous to CLK and decoded elsewhere.
// Summary of operation
// - Overlay command parameter acts like register write
// - Block 3 graphics when control bit 3
// - Block 1 graphics when control bit 2
// - Mix field selects OR, XOR, AND
// - One mixing method shared by whole layer
// - First layer text or graphics; others graphics
// - Sixteen-bit character base, two byte parameters
module lyo_overlay
	import lyo_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_N,
	input wire lyo_req_t REQ,
	input wire logic [7:0] RD_ADDR,
	input wire lyo_pix_t PIX,
	input wire logic [7:0] CHAR_CODE,
	input wire logic [3:0] CHAR_HEIGHT,
	output logic [7:0] RD_DATA,
	output logic PIX_OUT,
	output logic BLK1_GRAPHICS,
	output logic BLK3_GRAPHICS,
	output logic [15:0] PATTERN_ADDR
);
	// ****************************************
	// Register write decode
	// ****************************************
	logic [7:0] compose_ff, nxt_compose;
	logic [7:0] base_lo_ff, nxt_base_lo;
	logic [7:0] base_hi_ff, nxt_base_hi;
	logic param_idx_ff, nxt_param_idx;
	logic in_base_cmd_ff, nxt_in_base_cmd;
	logic in_ovl_cmd_ff, nxt_in_ovl_cmd;
	wire logic dir_wr = REQ.wr && !REQ.indirect;
	// In indirect mode addr=FF marks a command byte, otherwise a parameter
	wire logic cmd_wr = REQ.wr && REQ.indirect && (REQ.addr == 8'hFF);
	wire logic par_wr = REQ.wr && REQ.indirect && (REQ.addr != 8'hFF);
	wire logic wr_compose = (dir_wr && REQ.addr == LYO_OFS_COMPOSE)
		|| (par_wr && in_ovl_cmd_ff);
	wire logic wr_lo = (dir_wr && REQ.addr == LYO_OFS_BASE_LO)
		|| (par_wr && in_base_cmd_ff && !param_idx_ff);
	wire logic wr_hi = (dir_wr && REQ.addr == LYO_OFS_BASE_HI)
		|| (par_wr && in_base_cmd_ff && param_idx_ff);
	// Reserved bits are not stored so they always read back zero
	assign nxt_compose = wr_compose ? (REQ.data & LYO_COMPOSE_MASK) : compose_ff;
	assign nxt_base_lo = wr_lo ? REQ.data : base_lo_ff;
	assign nxt_base_hi = wr_hi ? REQ.data : base_hi_ff;
	// Command tracking: a new command byte ends the previous parameter run
	assign nxt_in_ovl_cmd = cmd_wr ? (REQ.data == LYO_CMD_OVERLAY)
		: (in_ovl_cmd_ff && !par_wr);
	assign nxt_in_base_cmd = cmd_wr ? (REQ.data == LYO_CMD_BASE)
		: (in_base_cmd_ff && !(par_wr && param_idx_ff));
	assign nxt_param_idx = cmd_wr ? 1'b0 : (par_wr && in_base_cmd_ff) ? 1'b1 : param_idx_ff;
	// ****************************************
	// Mixing logic
	// ****************************************
	wire logic [1:0] mix_method = compose_ff[LYO_BIT_MIX +: 2];
	wire logic blk1_gfx = compose_ff[LYO_BIT_BLK1];
	wire logic blk3_gfx = compose_ff[LYO_BIT_BLK3];
	// Third layer only with graphics first layer; host keeps bit 4 clear otherwise
	wire logic first_gfx = PIX.blk3 ? blk3_gfx : blk1_gfx;
	wire logic three_on = compose_ff[LYO_BIT_THREE] && first_gfx;
	wire logic third_bit = three_on && PIX.third;
	// Same method for both blocks of a layer: no per-block select exists
	wire logic base_mix = (mix_method == LYO_MIX_OR) ? (PIX.first | PIX.second)
		: (mix_method == LYO_MIX_XOR) ? (PIX.first ^ PIX.second)
		: (mix_method == LYO_MIX_AND) ? (PIX.first & PIX.second)
		: 1'b0;
	wire logic nxt_pix = base_mix | third_bit;
	// ****************************************
	// Character pattern address
	// ****************************************
	wire logic [15:0] base_addr = {base_hi_ff, base_lo_ff};
	// Widest product is 255 x 15, so twelve bits never overflow
	wire logic [11:0] code_offset = 12'(CHAR_CODE) * 12'(CHAR_HEIGHT);
	wire logic [15:0] nxt_pattern = base_addr + {4'h0, code_offset};
	wire logic [7:0] nxt_rd = (RD_ADDR == LYO_OFS_COMPOSE) ? compose_ff
		: (RD_ADDR == LYO_OFS_BASE_LO) ? base_lo_ff
		: (RD_ADDR == LYO_OFS_BASE_HI) ? base_hi_ff : 8'h00;
	// Registers, synchronous reset
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			compose_ff <= LYO_RST_COMPOSE;
			base_lo_ff <= LYO_RST_BASE;
			base_hi_ff <= LYO_RST_BASE;
			param_idx_ff <= 1'b0;
			in_base_cmd_ff <= 1'b0;
			in_ovl_cmd_ff <= 1'b0;
		end else begin
			compose_ff <= nxt_compose;
			base_lo_ff <= nxt_base_lo;
			base_hi_ff <= nxt_base_hi;
			param_idx_ff <= nxt_param_idx;
			in_base_cmd_ff <= nxt_in_base_cmd;
			in_ovl_cmd_ff <= nxt_in_ovl_cmd;
		end
	end
	// Outputs registered; one cycle of latency after inputs
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			RD_DATA <= 8'h00;
			PIX_OUT <= 1'b0;
			BLK1_GRAPHICS <= 1'b0;
			BLK3_GRAPHICS <= 1'b0;
			PATTERN_ADDR <= 16'h0000;
		end else begin
			RD_DATA <= nxt_rd;
			PIX_OUT <= nxt_pix;
			BLK1_GRAPHICS <= blk1_gfx;
			BLK3_GRAPHICS <= blk3_gfx;
			PATTERN_ADDR <= nxt_pattern;
		end
	end
	// ****************************************
	// Checks
	// ****************************************
	// Command steps; host leaves an idle cycle between bytes
	sequence s_ovl_cmd;
		cmd_wr && REQ.data == LYO_CMD_OVERLAY;
	endsequence
	sequence s_base_cmd;
		cmd_wr && REQ.data == LYO_CMD_BASE;
	endsequence
	sequence s_gap_param;
		!REQ.wr ##1 par_wr;
	endsequence
	chk_ovl_param_load: assert property (@(posedge CLK) disable iff (!RST_N)
		s_ovl_cmd ##1 s_gap_param |=> compose_ff == ($past(REQ.data) & LYO_COMPOSE_MASK))
		else $error("overlay parameter not loaded");
	chk_blk3_mode: assert property (@(posedge CLK) disable iff (!RST_N)
		1 |=> BLK3_GRAPHICS == $past(compose_ff[LYO_BIT_BLK3]))
		else $error("block 3 mode wrong");
	chk_blk1_mode: assert property (@(posedge CLK) disable iff (!RST_N)
		1 |=> BLK1_GRAPHICS == $past(compose_ff[LYO_BIT_BLK1]))
		else $error("block 1 mode wrong");
	chk_mix_xor: assert property (@(posedge CLK) disable iff (!RST_N)
		(mix_method == LYO_MIX_XOR && !third_bit) |=> PIX_OUT == $past(PIX.first ^ PIX.second))
		else $error("xor mix wrong");
	chk_mix_and: assert property (@(posedge CLK) disable iff (!RST_N)
		(mix_method == LYO_MIX_AND && !third_bit) |=> PIX_OUT == $past(PIX.first & PIX.second))
		else $error("and mix wrong");
	chk_third_gate: assert property (@(posedge CLK) disable iff (!RST_N)
		(!first_gfx && !PIX.first && !PIX.second) |=> !PIX_OUT)
		else $error("third layer used with text");
	chk_base_pair: assert property (@(posedge CLK) disable iff (!RST_N)
		s_base_cmd ##1 s_gap_param ##1 s_gap_param |=>
		base_hi_ff == $past(REQ.data) && base_lo_ff == $past(REQ.data, 3))
		else $error("base parameters misloaded");
	chk_pattern_addr: assert property (@(posedge CLK) disable iff (!RST_N)
		1 |=> PATTERN_ADDR == $past(base_addr) + $past(CHAR_CODE) * $past(CHAR_HEIGHT))
		else $error("pattern address wrong");
	// ****************************************
	// Direct path, stray parameter and readback checks
	// ****************************************
	// Direct write of the control byte, reserved bits dropped
	chk_direct_compose: assert property (@(posedge CLK) disable iff (!RST_N)
		(dir_wr && REQ.addr == LYO_OFS_COMPOSE) |=>
		compose_ff == ($past(REQ.data) & LYO_COMPOSE_MASK))
		else $error("direct control write lost");
	// Direct writes of both base bytes
	chk_direct_lo: assert property (@(posedge CLK) disable iff (!RST_N)
		(dir_wr && REQ.addr == LYO_OFS_BASE_LO) |=> base_lo_ff == $past(REQ.data))
		else $error("direct base low write lost");
	chk_direct_hi: assert property (@(posedge CLK) disable iff (!RST_N)
		(dir_wr && REQ.addr == LYO_OFS_BASE_HI) |=> base_hi_ff == $past(REQ.data))
		else $error("direct base high write lost");
	// A parameter with no open command must not touch any setting
	chk_stray_param: assert property (@(posedge CLK) disable iff (!RST_N)
		(par_wr && !in_ovl_cmd_ff && !in_base_cmd_ff) |=>
		$stable(compose_ff) && $stable(base_lo_ff) && $stable(base_hi_ff))
		else $error("stray parameter stored");
	// Readback of each mapped offset, one cycle late
	chk_rd_compose: assert property (@(posedge CLK) disable iff (!RST_N)
		(RD_ADDR == LYO_OFS_COMPOSE) |=> RD_DATA == $past(compose_ff))
		else $error("control readback wrong");
	chk_rd_base_lo: assert property (@(posedge CLK) disable iff (!RST_N)
		(RD_ADDR == LYO_OFS_BASE_LO) |=> RD_DATA == $past(base_lo_ff))
		else $error("base low readback wrong");
	chk_rd_base_hi: assert property (@(posedge CLK) disable iff (!RST_N)
		(RD_ADDR == LYO_OFS_BASE_HI) |=> RD_DATA == $past(base_hi_ff))
		else $error("base high readback wrong");
	// ****************************************
	// Remaining mix checks and base word check
	// ****************************************
	// Plain OR of the two lower layers
	chk_mix_or: assert property (@(posedge CLK) disable iff (!RST_N)
		(mix_method == LYO_MIX_OR && !third_bit) |=> PIX_OUT == $past(PIX.first | PIX.second))
		else $error("or mix wrong");
	// Reserved code passes only the third layer
	chk_mix_reserved: assert property (@(posedge CLK) disable iff (!RST_N)
		(mix_method == 2'h3 && !third_bit) |=> !PIX_OUT)
		else $error("reserved mix leaked");
	// A set third layer always shows when it is allowed
	chk_third_pass: assert property (@(posedge CLK) disable iff (!RST_N)
		third_bit |=> PIX_OUT)
		else $error("third layer dropped");
	// Block 3 pixels follow the block 3 mode bit, not block 1
	chk_third_block3: assert property (@(posedge CLK) disable iff (!RST_N)
		(PIX.blk3 && !blk3_gfx && mix_method == 2'h3) |=> !PIX_OUT)
		else $error("block 3 text let third layer in");
	// Character base register pair forms the 16-bit address
	chk_base_word: assert property (@(posedge CLK) disable iff (!RST_N)
		1 |=> $past(base_addr) == {$past(base_hi_ff), $past(base_lo_ff)})
		else $error("base word misassembled");
endmodule : lyo_overlay

// ---- sim/lyo_host.sv ----
// Host model: writes compose and base settings, direct or by command.
// Assumes calls start just after a rising CLK edge.
module lyo_host
	import lyo_pkg::*;
(
	input wire logic CLK,
	output lyo_req_t REQ
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****
	// Byte transfers
	// ****
	initial REQ = '0;
	// One strobe per byte; released address and data lines show inverted values, never the old ones
	task automatic send(input logic ind, input logic [7:0] a, input logic [7:0] d);
		REQ <= '{1'b1, ind, a, d};
		@(posedge CLK);
		REQ <= '{1'b0, 1'b0, ~a, ~d};
		@(posedge CLK);
	endtask : send
	// Overlay command, then its single parameter
	task automatic overlay_cmd(input logic [7:0] d);
		send(1'b1, 8'hFF, LYO_CMD_OVERLAY);
		send(1'b1, 8'h00, d);
	endtask : overlay_cmd
	// Base command, low byte before high byte
	task automatic base_cmd(input logic [7:0] lo, input logic [7:0] hi);
		send(1'b1, 8'hFF, LYO_CMD_BASE);
		send(1'b1, 8'h00, lo);
		send(1'b1, 8'h00, hi);
	endtask : base_cmd
endmodule : lyo_host

// ---- sim/lyo_overlay_tb.sv ----
// Self-checking bench for the overlay block with a host model.
// Assumes the package lyo_pkg and both modules are compiled first.
module lyo_overlay_tb
	import lyo_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLK = 0, RST_N = 0, pix_out, blk1, blk3;
	lyo_req_t req;
	lyo_pix_t pix = '0;
	logic [7:0] rd_addr = 0, code = 0, rd_data, c, r, q;
	logic [3:0] height = 0;
	logic [15:0] pat;
	int err_count = 0, comparisons = 0;
	lyo_host host (.CLK(CLK), .REQ(req));
	lyo_overlay dut (.CLK(CLK), .RST_N(RST_N), .REQ(req), .RD_ADDR(rd_addr), .PIX(pix),
		.CHAR_CODE(code), .CHAR_HEIGHT(height), .RD_DATA(rd_data), .PIX_OUT(pix_out),
		.BLK1_GRAPHICS(blk1), .BLK3_GRAPHICS(blk3), .PATTERN_ADDR(pat));
	// ****
	// Helpers
	// ****
	initial forever #20 CLK = ~CLK;
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	// Third layer only counts in a graphics block with bit 4 set
	function automatic logic exp_pix(input logic [7:0] k, input lyo_pix_t p);
		logic t;
		t = p.third & k[4] & (p.blk3 ? k[3] : k[2]);
		case (k[1:0])
			2'h0: return p.first | p.second | t;
			2'h1: return (p.first ^ p.second) | t;
			2'h2: return (p.first & p.second) | t;
			default: return t;
		endcase
	endfunction : exp_pix
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic final_report();
		$display("checks %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : final_report
	// Settled sampling, away from the launching edge
	task automatic look();
		repeat (3) @(posedge CLK);
		@(negedge CLK);
	endtask : look
	// Hang guard
	initial begin
		#100000;
		err_count++;
		final_report();
	end
	// ****
	// Main sequence
	// ****
	initial begin
		r = 8'h1E;
		repeat (6) @(posedge CLK);
		RST_N <= 1'b1;
		@(posedge CLK);
		// Reset values, including the unmapped offset 1Bh
		for (int i = 0; i < 4; i++) begin
			rd_addr <= LYO_OFS_COMPOSE + 8'(i);
			look();
			check(rd_data, 16'h0000);
			@(posedge CLK);
		end
		// Every mix code, both access paths, random pixels and base
		for (int i = 0; i < 24; i++) begin
			r = lfsr(r);
			q = lfsr(r);
			c = {r[7:2], i[1:0]};
			if (c[3:2] != 2'h3) c[4] = 1'b0;
			if (i[0]) begin
				host.overlay_cmd(c);
				host.base_cmd(r, q);
			end else begin
				host.send(1'b0, LYO_OFS_COMPOSE, c);
				host.send(1'b0, LYO_OFS_BASE_LO, r);
				host.send(1'b0, LYO_OFS_BASE_HI, q);
			end
			pix <= lyo_pix_t'(q[3:0]);
			code <= q;
			height <= r[3:0];
			rd_addr <= i[1] ? LYO_OFS_BASE_HI : LYO_OFS_COMPOSE;
			look();
			check(rd_data, i[1] ? {8'h00, q} : {8'h00, c & LYO_COMPOSE_MASK});
			check({blk3, blk1}, {14'h0, c[3], c[2]});
			check(pix_out, exp_pix(c, lyo_pix_t'(q[3:0])));
			check(pat, {q, r} + 16'(q) * 16'(r[3:0]));
			@(posedge CLK);
		end
		final_report();
	end
endmodule : lyo_overlay_tb
